// ### rtl/usb_oep_pkg.sv
// Purpose: Shared constants for the OUT endpoint descriptor block.
// Assumes: One clock domain, 32-bit AXI4-Lite register access.
// Notes:   Descriptor entry indices are word indices; byte address is four times the index.
package usb_oep_pkg;
  localparam int EP_COUNT     = 3;
  localparam int AXI_ADDR_W   = 7;
  localparam int BYTE_W       = 8;
  localparam int FIFO_DEPTH   = 8;
  localparam int COUNT_W      = 7;
  localparam int BUF_ADDR_W   = 11;
  localparam int BASE_PAD_W   = 3;

  // Entry indices inside one eight-entry descriptor.
  localparam logic [2:0] IDX_CONFIG  = 3'h0;
  localparam logic [2:0] IDX_X_BASE  = 3'h1;
  localparam logic [2:0] IDX_X_COUNT = 3'h2;
  localparam logic [2:0] IDX_Y_BASE  = 3'h5;
  localparam logic [2:0] IDX_Y_COUNT = 3'h6;

  // Address fields: endpoint slot in [6:5], entry index in [4:2].
  localparam int ADDR_EP_LSB    = 5;
  localparam int ADDR_ENTRY_LSB = 2;

  // Configuration byte fields.
  localparam int CFG_IRQ_EN_BIT = 2;
  localparam int CFG_STALL_BIT  = 3;
  localparam int CFG_DOUBLE_BUFFER_ENABLE_BIT   = 4;
  localparam int CFG_TOGGLE_BIT = 5;
  localparam int CFG_ISO_BIT    = 6;
  localparam int CFG_ENABLE_BIT = 7;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hFC;
  localparam int COUNT_NAK_BIT  = 7;

  // Reset values and limits.
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] BASE_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [6:0] MAX_PACKET  = 7'h40;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} handshake_t;
endpackage

// ### rtl/usb_oep_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, clock enable freezes all state.
// Notes:   Depth must be a power of two; pointers carry one wrap bit.
`timescale 1ns/10ps
module usb_oep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W:0]   wrPtr_reg;
  logic [PTR_W:0]   rdPtr_reg;
  logic             full;
  logic             empty;

  // Full when pointers differ only in the wrap bit.
  assign empty    = (wrPtr_reg == rdPtr_reg);
  assign full     = (wrPtr_reg[PTR_W] != rdPtr_reg[PTR_W]) &&
                    (wrPtr_reg[PTR_W-1:0] == rdPtr_reg[PTR_W-1:0]);
  assign inReady  = ce && !full;
  assign outValid = !empty;
  assign outData  = mem_reg[rdPtr_reg[PTR_W-1:0]];

  // Storage is written only; no reset needed on data words.
  always_ff @(posedge clk) begin
    if (ce && inValid && !full) begin
      mem_reg[wrPtr_reg[PTR_W-1:0]] <= inData;
    end
  end

  // Pointer update; flush discards anything left over.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else if (ce) begin
      if (flush) begin
        wrPtr_reg <= '0;
        rdPtr_reg <= '0;
      end else begin
        if (inValid && !full) wrPtr_reg <= wrPtr_reg + 1'b1;
        if (outReady && !empty) rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule // usb_oep_fifo

// ### rtl/usb_out_endpoint_descriptor.sv
// Purpose: OUT endpoint descriptors 1..3 with buffer manager and AXI4-Lite access.
// Assumes: Serial engine delivers token, data bytes and end-of-packet in order.
// Notes:   Behaviour rules are listed below.
// Function
// RULE1 - Completion raises interrupt only when enabled
// RULE2 - Stall bit answers STALL, never hardware-cleared
// RULE3 - Double buffer off uses X; on, toggle selects
// RULE4 - Toggle bit tracks current DATA0/DATA1 state
// RULE5 - Firmware keeps isochronous select at zero
// RULE6 - Disabled endpoint is never served
// RULE7 - X start address is base shifted three
// RULE8 - Y start address formed the same way
// RULE9 - Transfer starts at base; base never modified
// RULE10 - Counts 0..64 binary; larger values forbidden
// RULE11 - NAK clear: buffer empty, accepts packet
// RULE12 - NAK set: buffer full, answer NAK
// RULE13 - Eight-entry descriptor layout per endpoint
// RULE14 - Good packet: count, NAK, toggle, interrupt
// RULE15 - Firmware clears NAK after reading buffer
`timescale 1ns/10ps
module usb_out_endpoint_descriptor (
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 ce,
  input  wire logic [usb_oep_pkg::AXI_ADDR_W-1:0]   awaddr,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  input  wire logic [usb_oep_pkg::AXI_ADDR_W-1:0]   araddr,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  input  wire logic                                 tokenValid,
  input  wire logic [1:0]                           tokenEp,
  input  wire logic                                 rxByteValid,
  input  wire logic [usb_oep_pkg::BYTE_W-1:0]       rxByte,
  output logic                                      rxByteReady,
  input  wire logic                                 rxEndValid,
  input  wire logic                                 rxGood,
  input  wire logic                                 rxDataPid,
  output logic                                      hsValid,
  output usb_oep_pkg::handshake_t                   hsCode,
  output logic                                      ramWrite,
  output logic [usb_oep_pkg::BUF_ADDR_W-1:0]        ramAddr,
  output logic [usb_oep_pkg::BYTE_W-1:0]            ramData,
  input  wire logic                                 ramReady,
  output logic                                      irqValid,
  output logic [1:0]                                irqEp
);
  import usb_oep_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_FINISH} state_t;
  logic [7:0]         cfg_reg   [EP_COUNT];
  logic [7:0]         base_reg  [EP_COUNT][2];
  logic [7:0]         count_reg [EP_COUNT][2];
  state_t             state_reg;
  logic [1:0]         curEp_reg;
  logic               curBuf_reg;
  logic [COUNT_W-1:0] rxCount_reg;
  logic               overflow_reg;
  logic               endSeen_reg;
  logic               endGood_reg;
  logic               endPid_reg;
  logic [7:0]         rdataByte_reg;

  // Address decode shared by the read and write channels.
  function automatic logic [3:0] decode(input logic [AXI_ADDR_W-1:0] a);
    logic [1:0] ep;
    logic [2:0] ix;
    logic       ok;
    ep = a[ADDR_EP_LSB +: 2];
    ix = a[ADDR_ENTRY_LSB +: 3];
    ok = (ep < 2'(EP_COUNT)) && (ix == IDX_CONFIG || ix == IDX_X_BASE ||
         ix == IDX_X_COUNT || ix == IDX_Y_BASE || ix == IDX_Y_COUNT);
    return {ok, ix};
  endfunction

  logic [3:0] wDec;
  logic [3:0] rDec;
  logic [1:0] wEp;
  logic [1:0] rEp;
  logic       wrFire;
  logic       wrHit;
  assign wDec = decode(awaddr);
  assign rDec = decode(araddr);
  assign wEp  = awaddr[ADDR_EP_LSB +: 2];
  assign rEp  = araddr[ADDR_EP_LSB +: 2];

  // Address and data are taken together, only once the previous response is gone.
  assign awready = ce && awvalid && wvalid && !bvalid;
  assign wready  = awready;
  assign wrFire  = awready;
  assign wrHit   = wrFire && wDec[3] && wstrb[0];
  assign arready = ce && !rvalid;

  // Token decision from the addressed endpoint's descriptor.
  logic [1:0] tokIdx;
  logic       tokLegal;
  logic       tokBuf;
  logic [7:0] tokCfg;
  assign tokIdx   = tokenEp - 2'h1;
  assign tokLegal = (tokenEp != 2'h0) && (tokIdx < 2'(EP_COUNT));
  assign tokCfg   = tokLegal ? cfg_reg[tokIdx] : CFG_RESET;
  // RULE3 buffer selection
  assign tokBuf   = tokCfg[CFG_DOUBLE_BUFFER_ENABLE_BIT] & tokCfg[CFG_TOGGLE_BIT];

  logic acceptTok;
  logic nakTok;
  logic stallTok;
  // RULE6 enable gate
  assign stallTok  = tokenValid && state_reg == ST_IDLE && tokLegal &&
                     tokCfg[CFG_ENABLE_BIT] && tokCfg[CFG_STALL_BIT];
  // RULE12 full buffer
  assign nakTok    = tokenValid && state_reg == ST_IDLE && tokLegal &&
                     tokCfg[CFG_ENABLE_BIT] && !tokCfg[CFG_STALL_BIT] &&
                     count_reg[tokIdx][tokBuf][COUNT_NAK_BIT];
  // RULE11 empty buffer accepts
  assign acceptTok = tokenValid && state_reg == ST_IDLE && tokLegal &&
                     tokCfg[CFG_ENABLE_BIT] && !tokCfg[CFG_STALL_BIT] &&
                     !count_reg[tokIdx][tokBuf][COUNT_NAK_BIT];

  // Data path: bytes outside a receive phase are drained and dropped.
  logic            fifoInReady;
  logic            fifoOutValid;
  logic            fifoOutReady;
  logic [BYTE_W-1:0] fifoOutData;
  logic            recv;
  logic            atLimit;
  assign recv         = (state_reg == ST_RECV);
  assign atLimit      = (rxCount_reg == MAX_PACKET);
  assign rxByteReady  = recv ? fifoInReady : ce;
  assign ramWrite     = recv && fifoOutValid && !atLimit;
  assign fifoOutReady = recv && ce && (ramReady || atLimit);
  assign ramData      = fifoOutData;
  // RULE7 RULE8 start address
  assign ramAddr = {base_reg[curEp_reg][curBuf_reg], BASE_PAD_W'(0)} +
                   BUF_ADDR_W'(rxCount_reg);

  usb_oep_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) dataFifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .flush    (state_reg == ST_IDLE),
    .inValid  (recv && rxByteValid),
    .inReady  (fifoInReady),
    .inData   (rxByte),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  logic finishGood;
  logic finishNew;
  assign finishGood = state_reg == ST_FINISH && endGood_reg && !overflow_reg;
  // RULE4 sequence match
  assign finishNew  = finishGood &&
                      (endPid_reg == cfg_reg[curEp_reg][CFG_TOGGLE_BIT]);

  // Transaction sequencer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_IDLE;
      curEp_reg  <= 2'h0;
      curBuf_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (acceptTok) begin
            state_reg  <= ST_RECV;
            curEp_reg  <= tokIdx;
            curBuf_reg <= tokBuf;
          end
        end
        ST_RECV: begin
          if (endSeen_reg && !fifoOutValid) state_reg <= ST_FINISH;
        end
        ST_FINISH: state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // Byte counter and end-of-packet capture for the receive phase.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxCount_reg  <= 7'h00;
      overflow_reg <= 1'b0;
      endSeen_reg  <= 1'b0;
      endGood_reg  <= 1'b0;
      endPid_reg   <= 1'b0;
    end else if (ce) begin
      if (acceptTok) begin
        // RULE9 offset from base
        rxCount_reg  <= 7'h00;
        overflow_reg <= 1'b0;
        endSeen_reg  <= 1'b0;
      end else if (recv) begin
        if (ramWrite && ramReady) rxCount_reg <= rxCount_reg + 7'h01;
        if (fifoOutValid && atLimit) overflow_reg <= 1'b1;
        if (rxEndValid) begin
          endSeen_reg <= 1'b1;
          endGood_reg <= rxGood;
          endPid_reg  <= rxDataPid;
        end
      end
    end
  end

  // Configuration bytes; the toggle update from a completed packet wins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int e = 0; e < EP_COUNT; e++) cfg_reg[e] <= CFG_RESET;
    end else if (ce) begin
      for (int e = 0; e < EP_COUNT; e++) begin
        // RULE2 RULE6 software-owned bits
        if (wrHit && wEp == 2'(e) && wDec[2:0] == IDX_CONFIG) begin
          cfg_reg[e] <= wdata[7:0] & CFG_WRITE_MASK;
        end
        // RULE14 RULE4 toggle update
        if (finishNew && curEp_reg == 2'(e)) begin
          cfg_reg[e][CFG_TOGGLE_BIT] <= ~cfg_reg[e][CFG_TOGGLE_BIT];
        end
      end
    end
  end

  // Base addresses are written by software only.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int e = 0; e < EP_COUNT; e++) begin
        base_reg[e][0] <= BASE_RESET;
        base_reg[e][1] <= BASE_RESET;
      end
    end else if (ce && wrHit) begin
      for (int e = 0; e < EP_COUNT; e++) begin
        // RULE9 software-owned base
        if (wEp == 2'(e) && wDec[2:0] == IDX_X_BASE) base_reg[e][0] <= wdata[7:0];
        if (wEp == 2'(e) && wDec[2:0] == IDX_Y_BASE) base_reg[e][1] <= wdata[7:0];
      end
    end
  end

  // Count and NAK; a completed packet's set wins over a same-cycle write.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int e = 0; e < EP_COUNT; e++) begin
        count_reg[e][0] <= COUNT_RESET;
        count_reg[e][1] <= COUNT_RESET;
      end
    end else if (ce) begin
      for (int e = 0; e < EP_COUNT; e++) begin
        for (int b = 0; b < 2; b++) begin
          // RULE15 firmware frees buffer
          if (wrHit && wEp == 2'(e) &&
              wDec[2:0] == (b == 0 ? IDX_X_COUNT : IDX_Y_COUNT)) begin
            count_reg[e][b] <= wdata[7:0];
          end
          // RULE14 RULE10 count and NAK
          if (finishNew && curEp_reg == 2'(e) && curBuf_reg == 1'(b)) begin
            count_reg[e][b] <= {1'b1, rxCount_reg};
          end
        end
      end
    end
  end

  // Handshake and interrupt strobes, one cycle each.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hsValid  <= 1'b0;
      hsCode   <= HS_ACK;
      irqValid <= 1'b0;
      irqEp    <= 2'h0;
    end else if (ce) begin
      hsValid  <= stallTok || nakTok || finishGood;
      irqValid <= 1'b0;
      // RULE2 stall answer
      if (stallTok) hsCode <= HS_STALL;
      else if (nakTok) hsCode <= HS_NAK;
      else if (finishGood) hsCode <= HS_ACK;
      // RULE1 completion interrupt
      if (finishNew && cfg_reg[curEp_reg][CFG_IRQ_EN_BIT]) begin
        irqValid <= 1'b1;
        irqEp    <= curEp_reg + 2'h1;
      end
    end
  end

  // Write response channel.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp  <= AXI_OKAY;
    end else if (ce) begin
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp  <= wDec[3] ? AXI_OKAY : AXI_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel; RULE13 entry layout.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid        <= 1'b0;
      rresp         <= AXI_OKAY;
      rdataByte_reg <= 8'h00;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= rDec[3] ? AXI_OKAY : AXI_SLVERR;
        rdataByte_reg <= 8'h00;
        if (rDec[3]) begin
          case (rDec[2:0])
            IDX_CONFIG:  rdataByte_reg <= cfg_reg[rEp];
            IDX_X_BASE:  rdataByte_reg <= base_reg[rEp][0];
            IDX_X_COUNT: rdataByte_reg <= count_reg[rEp][0];
            IDX_Y_BASE:  rdataByte_reg <= base_reg[rEp][1];
            IDX_Y_COUNT: rdataByte_reg <= count_reg[rEp][1];
            default:     rdataByte_reg <= 8'h00;
          endcase
        end
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Upper bits of every register read as zero.
  assign rdata = {24'h00_0000, rdataByte_reg};
endmodule // usb_out_endpoint_descriptor

// ### tb/usb_oep_checker.sv
// Purpose: Port-level assertions for the OUT endpoint descriptor block.
// Assumes: One clock; reset_n is asynchronous and active low.
// Notes:   Attached by the bind statement at the foot of this file.
`timescale 1ns/10ps
module usb_oep_checker (
  input logic                     clk,
  input logic                     reset_n,
  input logic                     awvalid,
  input logic                     wvalid,
  input logic                     awready,
  input logic                     bvalid,
  input logic                     arvalid,
  input logic                     arready,
  input logic                     rvalid,
  input logic [31:0]              rdata,
  input logic                     tokenValid,
  input logic                     hsValid,
  input usb_oep_pkg::handshake_t  hsCode,
  input logic                     irqValid,
  input logic [1:0]               irqEp,
  input logic                     ramWrite,
  input logic                     ramReady,
  input logic [10:0]              ramAddr,
  input logic [7:0]               ramData
);
  import usb_oep_pkg::*;

  // Every check uses the one clock and sleeps while reset is low.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Interrupt requests only ride on an accepted packet.
  AST_IRQ_ON_ACK: assert property (irqValid |-> hsValid && hsCode == HS_ACK)
    else $error("interrupt without ACK handshake");
  AST_IRQ_EP: assert property (irqValid |-> irqEp != 2'h0)
    else $error("interrupt names endpoint zero");

  // Handshakes are single-cycle; refusals answer the token at once.
  AST_HS_PULSE: assert property (hsValid |=> !hsValid)
    else $error("handshake held too long");
  AST_REFUSE_NEXT: assert property (hsValid && hsCode != HS_ACK |-> $past(tokenValid))
    else $error("refusal not one cycle after token");

  // A stalled buffer write must keep its address and byte steady.
  AST_RAM_HOLD: assert property (ramWrite && !ramReady |=> ramWrite && $stable(ramAddr)
    && $stable(ramData)) else $error("buffer write changed while stalled");

  // Register bus answers one cycle after acceptance, one at a time.
  AST_W_ANSWER: assert property (awvalid && wvalid && awready |=> bvalid)
    else $error("write response missing");
  AST_ONE_WRITE: assert property (bvalid |-> !awready)
    else $error("write taken while response pending");
  AST_R_ANSWER: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h00_0000)
    else $error("read answer late or upper bits set");
  AST_ONE_READ: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");

  // Main traffic kinds seen at least once.
  COV_STALL: cover property (hsValid && hsCode == HS_STALL);
  COV_NAK: cover property (hsValid && hsCode == HS_NAK);
  COV_IRQ: cover property (irqValid);
  COV_RAM_STALL: cover property (ramWrite && !ramReady);
endmodule // usb_oep_checker

bind usb_out_endpoint_descriptor usb_oep_checker chk_u (
  .clk(clk), .reset_n(reset_n), .awvalid(awvalid), .wvalid(wvalid), .awready(awready),
  .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
  .tokenValid(tokenValid), .hsValid(hsValid), .hsCode(hsCode), .irqValid(irqValid),
  .irqEp(irqEp), .ramWrite(ramWrite), .ramReady(ramReady), .ramAddr(ramAddr),
  .ramData(ramData)
);

// ### tb/usb_oep_ram_model.sv
// Purpose: Buffer RAM standing on the far side of the block's write port.
// Assumes: At most one byte written per cycle.
// Notes:   Slow mode grants one write in four, so the FIFO backs up.
`timescale 1ns/10ps
module usb_oep_ram_model (
  input  wire logic        clk,
  input  wire logic        slowMode,
  input  wire logic        ramWrite,
  input  wire logic [10:0] ramAddr,
  input  wire logic [7:0]  ramData,
  output logic             ramReady
);
  logic [7:0] memArray [0:2047];
  logic [1:0] phaseCnt = 2'h0;

  // Free-running phase paces the grants; a real RAM arbiter is no kinder.
  always @(posedge clk) begin
    phaseCnt <= phaseCnt + 2'h1;
    if (ramWrite && ramReady) begin
      memArray[ramAddr] <= ramData;
    end
  end

  // Ready is granted every cycle unless slow mode is on.
  assign ramReady = !slowMode || (phaseCnt == 2'h3);
endmodule // usb_oep_ram_model

// ### tb/usb_out_endpoint_descriptor_bench.sv
// Purpose: Self-checking bench for the OUT endpoint descriptor block.
// Assumes: 200 MHz clock; the bench plays firmware and serial engine.
// Notes:   Register cases run from a table; packet cases follow by hand.
`timescale 1ns/10ps
module usb_out_endpoint_descriptor_bench;
  import usb_oep_pkg::*;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wval;
    logic [7:0] rval;
    logic [1:0] resp;
  } reg_row_t;
  logic        clk, reset_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, tokenValid, rxByteValid, rxByteReady;
  logic        rxEndValid, rxGood, rxDataPid, hsValid, ramWrite, ramReady, irqValid;
  logic        slowMode, hsSeen, irqSeen;
  logic [6:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, gotData;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, tokenEp, irqEp, gotResp, hsGot, irqEpGot;
  logic [7:0]  rxByte, ramData;
  logic [10:0] ramAddr;
  handshake_t  hsCode;
  int          errorCnt = 0, compares = 0, cycleCnt = 0, refusals;
  // Rows: address, written byte, expected read-back, expected response.
  reg_row_t regRows [8] = '{
    '{7'h00, 8'hBF, 8'hBC, AXI_OKAY}, '{7'h24, 8'hA5, 8'hA5, AXI_OKAY},
    '{7'h48, 8'h3F, 8'h3F, AXI_OKAY}, '{7'h14, 8'h5A, 8'h5A, AXI_OKAY},
    '{7'h38, 8'hC0, 8'hC0, AXI_OKAY}, '{7'h0C, 8'h77, 8'h00, AXI_SLVERR},
    '{7'h5C, 8'h77, 8'h00, AXI_SLVERR}, '{7'h60, 8'h77, 8'h00, AXI_SLVERR}};

  usb_out_endpoint_descriptor dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tokenValid(tokenValid), .tokenEp(tokenEp),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxByteReady(rxByteReady),
    .rxEndValid(rxEndValid), .rxGood(rxGood), .rxDataPid(rxDataPid), .hsValid(hsValid),
    .hsCode(hsCode), .ramWrite(ramWrite), .ramAddr(ramAddr), .ramData(ramData),
    .ramReady(ramReady), .irqValid(irqValid), .irqEp(irqEp));
  usb_oep_ram_model ram_u (.clk(clk), .slowMode(slowMode), .ramWrite(ramWrite),
    .ramAddr(ramAddr), .ramData(ramData), .ramReady(ramReady));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic completeRun;
    if (errorCnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard: far above the fewer than two thousand cycles the tests need.
  always @(posedge clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 20000) begin
      errorCnt++;
      completeRun();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write and read hold valid until ready, then wait for the answer.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    gotResp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    gotData = rdata;
    gotResp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [31:0] e);
    rd(a);
    chk(gotData, e);
  endtask

  task automatic ramchk(input logic [10:0] a, input logic [7:0] e);
    chk(32'(ram_u.memArray[a]), 32'(e));
  endtask

  // Token, n bytes (byte k is k+0x30), end of packet when n is nonzero; then catch the handshake.
  task automatic pkt(input logic [1:0] ep, input int n, input logic pid);
    refusals = 0;
    tokenEp <= ep;
    tokenValid <= 1'b1;
    @(posedge clk);
    tokenValid <= 1'b0;
    for (int k = 0; k < n; k++) begin
      rxByte <= 8'(k + 48);
      rxByteValid <= 1'b1;
      @(posedge clk);
      while (rxByteReady !== 1'b1) begin
        refusals++;
        @(posedge clk);
      end
    end
    if (n > 0) begin
      rxByteValid <= 1'b0;
      rxDataPid <= pid;
      rxEndValid <= 1'b1;
      @(posedge clk);
      rxEndValid <= 1'b0;
    end
    hsSeen = 1'b0;
    irqSeen = 1'b0;
    hsGot = 2'h0;
    irqEpGot = 2'h0;
    for (int i = 0; i < 300 && hsSeen !== 1'b1; i++) begin
      @(posedge clk);
      if (hsValid === 1'b1) begin
        hsSeen = 1'b1;
        hsGot = hsCode;
        irqSeen = irqValid;
        irqEpGot = (irqValid === 1'b1) ? irqEp : 2'h0;
      end
    end
  endtask

  task automatic outcome(input logic [5:0] e);
    chk(32'({hsSeen, hsGot, irqSeen, irqEpGot}), 32'(e));
  endtask

  // Main sequence: reset, register table, then packet cases.
  initial begin
    {ce, wstrb, rxGood} = {1'b1, 4'hF, 1'b1};
    {awvalid, wvalid, bready, arvalid, rready, tokenValid} = 6'h00;
    {rxByteValid, rxEndValid, rxDataPid, slowMode} = 4'h0;
    {awaddr, araddr, wdata, tokenEp, rxByte} = '0;
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(7'h00, 32'h0000_0000);
    rdchk(7'h58, 32'h0000_0000);
    foreach (regRows[i]) begin
      wr(regRows[i].addr, regRows[i].wval);
      chk(32'(gotResp), 32'(regRows[i].resp));
      rd(regRows[i].addr);
      chk(gotData, 32'(regRows[i].rval));
      chk(32'(gotResp), 32'(regRows[i].resp));
    end
    // Endpoint 1, single buffer, interrupt on: packet lands at base*8.
    wr(7'h00, 8'h84);
    wr(7'h04, 8'h10);
    wr(7'h08, 8'h00);
    pkt(2'h1, 3, 1'b0);
    outcome({1'b1, HS_ACK, 1'b1, 2'h1});
    ramchk(11'h080, 8'h30);
    ramchk(11'h082, 8'h32);
    rdchk(7'h08, 32'h0000_0083);
    rdchk(7'h00, 32'h0000_00A4);
    rdchk(7'h04, 32'h0000_0010);
    pkt(2'h1, 0, 1'b1);
    outcome({1'b1, HS_NAK, 1'b0, 2'h0});
    // Stall wins and stays set after the handshake.
    wr(7'h00, 8'hAC);
    pkt(2'h1, 0, 1'b1);
    outcome({1'b1, HS_STALL, 1'b0, 2'h0});
    rdchk(7'h00, 32'h0000_00AC);
    // Disabled endpoint 2 is ignored outright.
    wr(7'h20, 8'h04);
    wr(7'h28, 8'h00);
    pkt(2'h2, 2, 1'b0);
    outcome({1'b0, HS_ACK, 1'b0, 2'h0});
    rdchk(7'h28, 32'h0000_0000);
    // Endpoint 3 double-buffered, no interrupt: X then Y.
    wr(7'h40, 8'h90);
    wr(7'h44, 8'h20);
    wr(7'h48, 8'h00);
    wr(7'h54, 8'h30);
    wr(7'h58, 8'h00);
    pkt(2'h3, 2, 1'b0);
    outcome({1'b1, HS_ACK, 1'b0, 2'h0});
    ramchk(11'h100, 8'h30);
    pkt(2'h3, 2, 1'b1);
    outcome({1'b1, HS_ACK, 1'b0, 2'h0});
    ramchk(11'h181, 8'h31);
    rdchk(7'h58, 32'h0000_0082);
    rdchk(7'h40, 32'h0000_0090);
    // Slow RAM fills the FIFO: 64 bytes pass, 65 are rejected.
    slowMode <= 1'b1;
    wr(7'h00, 8'hA0);
    wr(7'h08, 8'h00);
    pkt(2'h1, 64, 1'b1);
    outcome({1'b1, HS_ACK, 1'b0, 2'h0});
    chk(32'(refusals > 0), 32'h0000_0001);
    rdchk(7'h08, 32'h0000_00C0);
    ramchk(11'h0BF, 8'h6F);
    wr(7'h08, 8'h00);
    pkt(2'h1, 65, 1'b0);
    outcome({1'b0, HS_ACK, 1'b0, 2'h0});
    rdchk(7'h08, 32'h0000_0000);
    rxGood <= 1'b0;
    pkt(2'h1, 1, 1'b0);
    outcome({1'b0, HS_ACK, 1'b0, 2'h0});
    rxGood <= 1'b1;
    pkt(2'h1, 1, 1'b1);
    outcome({1'b1, HS_ACK, 1'b0, 2'h0});
    rdchk(7'h08, 32'h0000_0000);
    slowMode <= 1'b0;
    // Second reset in mid-run clears the descriptors.
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(7'h00, 32'h0000_0000);
    completeRun();
  end
endmodule // usb_out_endpoint_descriptor_bench
